// >>> logic/ettc_map.svh
// Purpose: offsets, field positions, reset values and codes of the timer
// Assumes: byte-wide register port with 8-bit addresses
// Notes: definitions only
`ifndef ETTC_MAP_SVH
`define ETTC_MAP_SVH

// register addresses
`define ETTC_ADDR_COUNT 8'hCA
`define ETTC_ADDR_CTL 8'hCB
`define ETTC_ADDR_CCTL0 8'hCC
`define ETTC_ADDR_CC0 8'hCD
`define ETTC_ADDR_CCTL1 8'hCE
`define ETTC_ADDR_CC1 8'hCF
`define ETTC_ADDR_FLAGS 8'hD0
`define ETTC_ADDR_GIE 8'hD1

// timer control fields
`define ETTC_CTL_DIV_HI 7
`define ETTC_CTL_DIV_LO 5
`define ETTC_CTL_START 4
`define ETTC_CTL_WRAP_MASK 3
`define ETTC_CTL_CLEAR 2
`define ETTC_CTL_MODE_HI 1
`define ETTC_CTL_MODE_LO 0

// channel control fields
`define ETTC_CCTL_HI 6
`define ETTC_CCTL_LO 0

// event flag positions
`define ETTC_FLAG_WRAP 0
`define ETTC_FLAG_CH0 1
`define ETTC_FLAG_CH1 2

// reset values
`define ETTC_DIV_RESET 3'h0
`define ETTC_WRAP_MASK_RESET 1'h1
`define ETTC_CCTL_RESET 7'h40
`define ETTC_CC_RESET 8'h00
`define ETTC_FLAGS_RESET 3'h0

// counter landmarks and prescaler
`define ETTC_CNT_ZERO 8'h00
`define ETTC_CNT_ONE 8'h01
`define ETTC_CNT_TOP 8'hFF
`define ETTC_PRE_FULL 7'h7F

// compare action codes
`define ETTC_ACT_SET 3'h0
`define ETTC_ACT_CLEAR 3'h1
`define ETTC_ACT_TOGGLE 3'h2
`define ETTC_ACT_SET_UP 3'h3
`define ETTC_ACT_CLEAR_UP 3'h4
`define ETTC_ACT_SET_ALT 3'h5
`define ETTC_ACT_CLEAR_ALT 3'h6

`endif

// >>> logic/ettc_pkg.sv
// Purpose: types shared by the timer and its bench
// Assumes: constants live in ettc_map.svh
// Notes: mode enum order matches the two-bit mode field
package ettc_pkg;

    // counting modes, in field-code order
    typedef enum logic [1:0] {
        MODE_FREE,
        MODE_DOWN,
        MODE_MODULO,
        MODE_UPDOWN
    } ettc_mode_t;

    // one register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ettc_bus_req_t;

    // stored bits of a channel control register
    typedef struct packed {
        logic irq_mask;
        logic [2:0] action;
        logic enable;
        logic [1:0] spare;
    } ettc_chan_ctl_t;

endpackage

// >>> logic/ettc_top.sv
// Purpose: 8-bit timer with prescaler, four modes and two compare outputs
// Assumes: register port on clk_i, one request per cycle
// Notes: read data appear the cycle after the read strobe
//
// Behaviour
// - divider select 000..111 gives update edges at tick divided by 1..128
// - a new divider select changes the edge rate immediately
// - start bit 1 counts, 0 freezes the counter where it stands
// - writing 1 to counter_clear zeroes the counter; bit reads 0
// - counter_clear reads 0, including right after reset
// - mode 00 counts 0x00 to 0xFF and wraps, forever
// - mode 01 loads channel zero value and counts down once to 0x00
// - mode 10 counts 0x00 up to channel zero value, then restarts
// - mode 11 counts up to channel zero value and back down, forever
// - interrupt needs both the event mask and global enable set
// - each channel has its own interrupt mask, enabled from reset
// - actions 000/001/010 set, clear, toggle output on compare match
// - action 011 sets on up match, clears at zero or on down match
// - action 100 clears on up match, sets at zero or on down match
// - channel zero 101/110 pair compare with 0xFF clear or 0x00 set
// - channel one 101/110 pair compare with channel zero value
// - channel compare enable bit gates actions, resets to 0
// - compare values are 8-bit read/write, reset 0x00
// - channel zero value applies at counter 0x00; channel one at once
`timescale 1ns/1ps
`include "ettc_map.svh"

module ettc_top
    import ettc_pkg::*;
#(
    parameter int COUNT_WIDTH = 8,
    parameter int CHANNELS = 2
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register port
    input wire ettc_bus_req_t bus_i,
    output logic [7:0] rdata_o,
    // compare pins and interrupt request
    output logic [1:0] compare_out_o,
    output logic irq_o
);

    // the logic is built around an 8-bit counter and two channels
    if (COUNT_WIDTH != 8 || CHANNELS != 2)
    begin : g_check
        $error("ettc_top serves an 8-bit counter with two channels only");
    end

    logic [2:0] div_reg;
    logic start_reg;
    logic wrap_mask_reg;
    ettc_mode_t mode_reg;
    logic [7:0] cc0_reg;
    logic [7:0] cc0_live_reg;
    logic [7:0] cc1_reg;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic dir_down_reg;
    logic dir_next;
    logic [6:0] pre_reg;
    logic [6:0] div_mask;
    logic [2:0] flags_reg;
    logic [2:0] flags_next;
    logic gie_reg;
    logic irq_reg;
    logic [7:0] rdata_reg;
    logic [1:0] out_reg;
    logic [1:0] ch_evt;
    logic [1:0] ch_mask;
    ettc_chan_ctl_t cctl_reg [2];
    logic tick;
    logic run;
    logic wrap_evt;
    logic wr_ctl;
    logic load_down;
    logic updown;
    logic going_down;

    // strobes decoded from the register port
    assign wr_ctl = bus_i.wr && (bus_i.addr == `ETTC_ADDR_CTL);
    assign load_down = wr_ctl && bus_i.wdata[`ETTC_CTL_START] && !start_reg
        && (bus_i.wdata[`ETTC_CTL_MODE_HI:`ETTC_CTL_MODE_LO] == 2'h1);
    assign updown = (mode_reg == MODE_UPDOWN);
    assign going_down = updown && dir_down_reg;

    // free-running prescaler; the select only picks which low bits must
    // be all ones, so a change acts on the very next edge
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            pre_reg <= 7'h00;
        else
            pre_reg <= pre_reg + 7'h01;
    end

    assign div_mask = ~(`ETTC_PRE_FULL << div_reg);
    assign tick = ((pre_reg & div_mask) == div_mask);
    assign run = start_reg && tick;

    // timer control register fields
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            div_reg <= `ETTC_DIV_RESET;
            start_reg <= 1'b0;
            wrap_mask_reg <= `ETTC_WRAP_MASK_RESET;
            mode_reg <= MODE_FREE;
        end
        else if (wr_ctl)
        begin
            div_reg <= bus_i.wdata[`ETTC_CTL_DIV_HI:`ETTC_CTL_DIV_LO];
            start_reg <= bus_i.wdata[`ETTC_CTL_START];
            wrap_mask_reg <= bus_i.wdata[`ETTC_CTL_WRAP_MASK];
            mode_reg <= ettc_mode_t'(
                bus_i.wdata[`ETTC_CTL_MODE_HI:`ETTC_CTL_MODE_LO]);
        end
    end

    // compare value registers; channel one takes effect at once
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cc0_reg <= `ETTC_CC_RESET;
            cc1_reg <= `ETTC_CC_RESET;
        end
        else if (bus_i.wr)
        begin
            if (bus_i.addr == `ETTC_ADDR_CC0)
                cc0_reg <= bus_i.wdata;
            if (bus_i.addr == `ETTC_ADDR_CC1)
                cc1_reg <= bus_i.wdata;
        end
    end

    // working copy of channel zero value, refreshed only at zero
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            cc0_live_reg <= `ETTC_CC_RESET;
        else if (count_reg == `ETTC_CNT_ZERO)
            cc0_live_reg <= cc0_reg;
    end

    // next counter value and direction for one update edge
    always_comb
    begin
        count_next = count_reg;
        dir_next = dir_down_reg;
        wrap_evt = 1'b0;
        if (run)
        begin
            case (mode_reg)
                MODE_FREE:
                begin
                    count_next = count_reg + `ETTC_CNT_ONE;
                    wrap_evt = (count_reg == `ETTC_CNT_TOP);
                end
                MODE_DOWN:
                begin
                    if (count_reg != `ETTC_CNT_ZERO)
                    begin
                        count_next = count_reg - `ETTC_CNT_ONE;
                        wrap_evt = (count_reg == `ETTC_CNT_ONE);
                    end
                end
                MODE_MODULO:
                begin
                    if (count_reg == cc0_live_reg)
                    begin
                        count_next = `ETTC_CNT_ZERO;
                        wrap_evt = 1'b1;
                    end
                    else
                        count_next = count_reg + `ETTC_CNT_ONE;
                end
                MODE_UPDOWN:
                begin
                    if (!dir_down_reg)
                    begin
                        if (count_reg == cc0_live_reg)
                        begin
                            dir_next = 1'b1;
                            if (count_reg != `ETTC_CNT_ZERO)
                                count_next = count_reg - `ETTC_CNT_ONE;
                        end
                        else
                            count_next = count_reg + `ETTC_CNT_ONE;
                    end
                    else if (count_reg == `ETTC_CNT_ZERO)
                    begin
                        dir_next = 1'b0;
                        wrap_evt = 1'b1;
                        if (cc0_live_reg != `ETTC_CNT_ZERO)
                            count_next = `ETTC_CNT_ONE;
                    end
                    else
                        count_next = count_reg - `ETTC_CNT_ONE;
                end
                default:
                begin
                    count_next = count_reg;
                end
            endcase
        end
    end

    // counter: clear beats the down-mode load, which beats counting
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            count_reg <= `ETTC_CNT_ZERO;
            dir_down_reg <= 1'b0;
        end
        else if (wr_ctl && bus_i.wdata[`ETTC_CTL_CLEAR])
        begin
            count_reg <= `ETTC_CNT_ZERO;
            dir_down_reg <= 1'b0;
        end
        else if (load_down)
        begin
            count_reg <= cc0_live_reg;
            dir_down_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            dir_down_reg <= dir_next;
        end
    end

    // per-channel control, compare and output logic
    for (genvar g = 0; g < 2; g++)
    begin : g_chan
        localparam logic [7:0] CCTL_ADDR =
            (g == 0) ? `ETTC_ADDR_CCTL0 : `ETTC_ADDR_CCTL1;
        localparam logic [7:0] ALT_CLEAR_CH0 = `ETTC_CNT_TOP;
        localparam logic [7:0] ALT_SET_CH0 = `ETTC_CNT_ZERO;
        logic [7:0] cmp_val;
        logic match;
        logic at_zero;
        logic alt_clear_hit;
        logic alt_set_hit;

        assign cmp_val = (g == 0) ? cc0_live_reg : cc1_reg;
        assign match = run && (count_reg == cmp_val);
        assign at_zero = run && (count_reg == `ETTC_CNT_ZERO);
        // alternate landmark: fixed ends for channel zero, channel zero
        // value for channel one
        assign alt_clear_hit = run && (count_reg ==
            ((g == 0) ? ALT_CLEAR_CH0 : cc0_live_reg));
        assign alt_set_hit = run && (count_reg ==
            ((g == 0) ? ALT_SET_CH0 : cc0_live_reg));

        // channel zero flags the zero turnaround in up/down mode
        assign ch_evt[g] = (g == 0 && updown) ? wrap_evt : match;
        assign ch_mask[g] = cctl_reg[g].irq_mask;

        // channel control register, reserved bits stored as written
        always_ff @(posedge clk_i)
        begin
            if (reset_i)
                cctl_reg[g] <= ettc_chan_ctl_t'(`ETTC_CCTL_RESET);
            else if (bus_i.wr && bus_i.addr == CCTL_ADDR)
                cctl_reg[g] <= ettc_chan_ctl_t'(
                    bus_i.wdata[`ETTC_CCTL_HI:`ETTC_CCTL_LO]);
        end

        // compare pin; a match takes priority over the landmark action
        always_ff @(posedge clk_i)
        begin
            if (reset_i)
                out_reg[g] <= 1'b0;
            else if (cctl_reg[g].enable && run)
            begin
                case (cctl_reg[g].action)
                    `ETTC_ACT_SET:
                        if (match) out_reg[g] <= 1'b1;
                    `ETTC_ACT_CLEAR:
                        if (match) out_reg[g] <= 1'b0;
                    `ETTC_ACT_TOGGLE:
                        if (match) out_reg[g] <= ~out_reg[g];
                    `ETTC_ACT_SET_UP:
                        if (match && !going_down)
                            out_reg[g] <= 1'b1;
                        else if (updown ? (match && going_down) : at_zero)
                            out_reg[g] <= 1'b0;
                    `ETTC_ACT_CLEAR_UP:
                        if (match && !going_down)
                            out_reg[g] <= 1'b0;
                        else if (updown ? (match && going_down) : at_zero)
                            out_reg[g] <= 1'b1;
                    `ETTC_ACT_SET_ALT:
                        if (match)
                            out_reg[g] <= 1'b1;
                        else if (alt_clear_hit)
                            out_reg[g] <= 1'b0;
                    `ETTC_ACT_CLEAR_ALT:
                        if (match)
                            out_reg[g] <= 1'b0;
                        else if (alt_set_hit)
                            out_reg[g] <= 1'b1;
                    default:
                        out_reg[g] <= out_reg[g];
                endcase
            end
        end
    end

    // sticky event flags: write 1 clears, a new event wins the same cycle
    always_comb
    begin
        flags_next = flags_reg;
        if (bus_i.wr && bus_i.addr == `ETTC_ADDR_FLAGS)
            flags_next = flags_reg & ~bus_i.wdata[2:0];
        flags_next[`ETTC_FLAG_WRAP] = flags_next[`ETTC_FLAG_WRAP] | wrap_evt;
        flags_next[`ETTC_FLAG_CH0] = flags_next[`ETTC_FLAG_CH0] | ch_evt[0];
        flags_next[`ETTC_FLAG_CH1] = flags_next[`ETTC_FLAG_CH1] | ch_evt[1];
    end

    // flags and global interrupt enable
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            flags_reg <= `ETTC_FLAGS_RESET;
            gie_reg <= 1'b0;
        end
        else
        begin
            flags_reg <= flags_next;
            if (bus_i.wr && bus_i.addr == `ETTC_ADDR_GIE)
                gie_reg <= bus_i.wdata[0];
        end
    end

    // interrupt request: a pending flag under its own mask and the global
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            irq_reg <= 1'b0;
        else
            irq_reg <= gie_reg && |(flags_reg &
                {ch_mask[1], ch_mask[0], wrap_mask_reg});
    end

    // read data, registered one cycle after the read strobe
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            rdata_reg <= 8'h00;
        else if (bus_i.rd)
        begin
            case (bus_i.addr)
                `ETTC_ADDR_COUNT: rdata_reg <= count_reg;
                `ETTC_ADDR_CTL: rdata_reg <= {div_reg, start_reg,
                    wrap_mask_reg, 1'b0, mode_reg};
                `ETTC_ADDR_CCTL0: rdata_reg <= {1'b0, cctl_reg[0]};
                `ETTC_ADDR_CC0: rdata_reg <= cc0_reg;
                `ETTC_ADDR_CCTL1: rdata_reg <= {1'b0, cctl_reg[1]};
                `ETTC_ADDR_CC1: rdata_reg <= cc1_reg;
                `ETTC_ADDR_FLAGS: rdata_reg <= {5'h00, flags_reg};
                `ETTC_ADDR_GIE: rdata_reg <= {7'h00, gie_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    // outputs straight from flip-flops
    assign rdata_o = rdata_reg;
    assign compare_out_o = out_reg;
    assign irq_o = irq_reg;

endmodule

// >>> testbench/ettc_checker.sv
// Purpose: port-level checks of the eight-bit timer
// Assumes: register shadows follow the writes seen on the bus port
// Notes: bound to every timer instance
`timescale 1ns/1ps
module ettc_checker
    import ettc_pkg::*;
#(
    parameter int COUNT_WIDTH = 8,
    parameter int CHANNELS = 2
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register port and outputs
    input wire ettc_bus_req_t bus_i,
    input wire logic [7:0] rdata_o,
    input wire logic [1:0] compare_out_o,
    input wire logic irq_o
);
    logic [7:0] ctl_reg, cc0_reg, cc1_reg;
    logic [6:0] cctl0_reg, cctl1_reg;
    logic gie_reg, cnt_rd;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // count read strobe
    assign cnt_rd = bus_i.rd && bus_i.addr == 8'hCA;
    // shadows of the writable registers
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ctl_reg <= 8'h08;
            cctl0_reg <= 7'h40;
            cctl1_reg <= 7'h40;
            cc0_reg <= 8'h00;
            cc1_reg <= 8'h00;
            gie_reg <= 1'b0;
        end
        else if (bus_i.wr)
        begin
            case (bus_i.addr)
                8'hCB: ctl_reg <= bus_i.wdata & 8'hFB; // clear never stored
                8'hCC: cctl0_reg <= bus_i.wdata[6:0];
                8'hCD: cc0_reg <= bus_i.wdata;
                8'hCE: cctl1_reg <= bus_i.wdata[6:0];
                8'hCF: cc1_reg <= bus_i.wdata;
                8'hD1: gie_reg <= bus_i.wdata[0];
                default: ;
            endcase
        end
    end

    ctl_read_a: assert property (bus_i.rd && bus_i.addr == 8'hCB
        |=> rdata_o == $past(ctl_reg)) else $error("control readback wrong");
    chan_ctl_a: assert property (bus_i.rd
        && bus_i.addr[7:2] == 6'h33 && !bus_i.addr[0] |=> rdata_o == {1'b0,
        $past(bus_i.addr[1] ? cctl1_reg : cctl0_reg)})
        else $error("channel control readback wrong");
    cc_value_a: assert property (bus_i.rd && bus_i.addr[7:2] == 6'h33
        && bus_i.addr[0] |=> rdata_o ==
        $past(bus_i.addr[1] ? cc1_reg : cc0_reg))
        else $error("compare value readback wrong");
    freeze_a: assert property (cnt_rd && !ctl_reg[4] ##1
        !ctl_reg[4] && !bus_i.wr ##1 cnt_rd && !ctl_reg[4]
        |=> rdata_o == $past(rdata_o)) else $error("stopped count moved");
    clear_zero_a: assert property (bus_i.wr && bus_i.addr == 8'hCB
        && bus_i.wdata[2] && !bus_i.wdata[4] ##1 !bus_i.wr ##1 cnt_rd
        |=> rdata_o == 8'h00) else $error("count not zero after clear");
    gie_gate_a: assert property (!$past(gie_reg) |-> !irq_o)
        else $error("request without global enable");
    mask_gate_a: assert property (!$past(ctl_reg[3]
        || cctl0_reg[6] || cctl1_reg[6]) |-> !irq_o)
        else $error("request with all masks off");
    pin_hold0_a: assert property (!cctl0_reg[2]
        || cctl0_reg[5:3] == 3'h7 |=> $stable(compare_out_o[0]))
        else $error("channel zero pin moved");
    pin_hold1_a: assert property (!cctl1_reg[2]
        || cctl1_reg[5:3] == 3'h7 |=> $stable(compare_out_o[1]))
        else $error("channel one pin moved");

    // main scenarios reached
    cover property ($rose(irq_o));
    cover property ($rose(compare_out_o[1]));
    cover property ($fell(compare_out_o[0]));
endmodule

bind ettc_top ettc_checker #(.COUNT_WIDTH(COUNT_WIDTH), .CHANNELS(CHANNELS))
    ettc_checker_inst (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .compare_out_o(compare_out_o), .irq_o(irq_o));

// >>> testbench/ettc_cpu_model.sv
// Purpose: cpu-side register master for the timer
// Assumes: tasks are entered right after a rising edge of clk_i
// Notes: every access takes two cycles; read data taken after the strobe
`timescale 1ns/1ps
module ettc_cpu_model
    import ettc_pkg::*;
(
    // clock
    input wire logic clk_i,
    // register port
    output ettc_bus_req_t bus_o,
    input wire logic [7:0] rdata_i
);
    // idle bus from time zero
    initial bus_o = '0;

    // one write cycle, then one idle edge so back-to-back calls never
    // assign the strobe twice in one step; spare bits kept at 00
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_o.addr <= a;
        bus_o.wdata <= (a == 8'hCC || a == 8'hCE) ? d & 8'hFC : d;
        bus_o.wr <= 1'b1;
        @(posedge clk_i);
        bus_o.wr <= 1'b0;
        @(posedge clk_i);
    endtask

    // one read cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bus_o.addr <= a;
        bus_o.rd <= 1'b1;
        @(posedge clk_i);
        bus_o.rd <= 1'b0;
        @(negedge clk_i);
        d = rdata_i;
        @(posedge clk_i);
    endtask
endmodule

// >>> testbench/testbench.sv
// Purpose: self-checking bench for the eight-bit timer
// Assumes: the cpu model drives the register port
// Notes: counts and pin levels are predicted from settings and run length
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
$display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module testbench
    import ettc_pkg::*;
;
    logic clk_i, reset_i, irq;
    ettc_bus_req_t bus;
    logic [7:0] rdata, v;
    logic [1:0] pins, ep;
    int mismatches = 0, n_tests = 0;
    int unsigned m, n, c;
    logic [7:0] ra [9] = '{8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCE, 8'hCF,
        8'hD0, 8'hD1, 8'hD5};
    logic [7:0] rv [9] = '{8'h00, 8'h08, 8'h40, 8'h00, 8'h40, 8'h00,
        8'h00, 8'h00, 8'h00};

    ettc_top ettc_top_inst (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus),
        .rdata_o(rdata), .compare_out_o(pins), .irq_o(irq));
    ettc_cpu_model ettc_cpu_model_inst (.clk_i(clk_i), .bus_o(bus),
        .rdata_i(rdata));

    // 200 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic w(input logic [7:0] a, input logic [7:0] x);
        ettc_cpu_model_inst.wr(a, x);
    endtask

    task automatic r(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] got;
        ettc_cpu_model_inst.rd(a, got);
        `CHK(got, e)
    endtask

    // pins and request looked at mid-cycle
    task automatic chk_out(input logic [1:0] e, input logic ei);
        @(negedge clk_i);
        `CHK(pins, e)
        `CHK(irq, ei)
        @(posedge clk_i);
    endtask

    // count after t update edges from zero
    function automatic logic [7:0] exp_cnt(input int md, k, t);
        int p;
        p = (k == 0) ? 0 : t % (2 * k);
        case (md)
            0: return 8'(t % 256);
            1: return (t >= k) ? 8'h00 : 8'(k - t);
            2: return 8'(t % (k + 1));
            default: return 8'((p <= k) ? p : 2 * k - p);
        endcase
    endfunction

    // pin after one run that meets zero, then ch1 match, then ch0 value
    function automatic logic exp_pin(input int code, ch, input logic p);
        case (code)
            0, 3: return 1'b1;
            1, 4: return 1'b0;
            2: return ~p;
            5: return ch == 0;
            6: return ch != 0;
            default: return p;
        endcase
    endfunction

    // start for t clock cycles (t of 2 or more), then stop
    task automatic run(input logic [7:0] ctl, input int t);
        w(8'hCB, ctl | 8'h10);
        repeat (t - 2) @(posedge clk_i);
        w(8'hCB, ctl & 8'hEB);
    endtask

    task automatic mode_run(input int dv, md, k, t);
        logic [7:0] b;
        b = 8'(dv << 5) | 8'(md) | 8'h08;
        w(8'hCD, 8'(k));
        w(8'hCB, b | 8'h04);
        r(8'hCA, 8'h00);
        run(b, t);
        r(8'hCA, exp_cnt(md, k, t >> dv));
        r(8'hCA, exp_cnt(md, k, t >> dv));
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // hang guard, well past the expected run length
    initial
    begin
        #100000;
        mismatches++;
        summarize();
    end

    initial
    begin
        void'($urandom(30));
        reset_i = 1'b1;
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 9; i++)
            r(ra[i], rv[i]);
        // every action code on both channels, then one disabled toggle
        ep = 2'b00;
        w(8'hCB, 8'h0C);
        w(8'hCD, 8'h14);
        w(8'hCF, 8'h0A);
        repeat (2) @(posedge clk_i);
        for (int code = 0; code < 9; code++)
        begin
            v = (code == 8) ? 8'h50 : 8'h44 | 8'(code << 3);
            w(8'hCC, v);
            w(8'hCE, v);
            run(8'h0C, 24);
            if (code < 8)
                ep = {exp_pin(code, 1, ep[1]), exp_pin(code, 0, ep[0])};
            chk_out(ep, 1'b0);
        end
        // request gating by flags, masks and global enable
        w(8'hD0, 8'h07);
        w(8'hD1, 8'h01);
        r(8'hD0, 8'h00);
        w(8'hCC, 8'h44);
        w(8'hCE, 8'h44);
        run(8'h0C, 24);
        @(posedge clk_i);
        chk_out(2'b11, 1'b1);
        r(8'hD0, 8'h06);
        w(8'hCC, 8'h04);
        w(8'hCE, 8'h04);
        w(8'hCB, 8'h00);
        @(posedge clk_i);
        chk_out(2'b11, 1'b0);
        w(8'hCE, 8'h44);
        @(posedge clk_i);
        chk_out(2'b11, 1'b1);
        w(8'hD1, 8'h00);
        @(posedge clk_i);
        chk_out(2'b11, 1'b0);
        // up/down mode: channel one meets its value going up and down
        for (int code = 3; code < 5; code++)
        begin
            w(8'hCC, 8'h04 | 8'(code << 3));
            w(8'hCE, 8'h04 | 8'(code << 3));
            run(8'h0F, 35);
            chk_out({code == 4, code == 3}, 1'b0);
        end
        // random register traffic
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($urandom);
            w(8'hCF, v);
            r(8'hCF, v);
            w(8'hCD, ~v);
            r(8'hCD, ~v);
            w(i[0] ? 8'hCE : 8'hCC, v);
            r(i[0] ? 8'hCE : 8'hCC, {1'b0, v[6:2], 2'b00});
            w(8'hCB, v & 8'hEF);
            r(8'hCB, v & 8'hEB);
        end
        // divider ratios, live divider change, modes
        for (int d = 0; d < 8; d++)
            mode_run(d, 0, 0, 128);
        w(8'hCB, 8'h0C);
        w(8'hCB, 8'h18);
        repeat (62) @(posedge clk_i);
        w(8'hCB, 8'h38);
        repeat (62) @(posedge clk_i);
        w(8'hCB, 8'h28);
        r(8'hCA, 8'h60);
        mode_run(0, 0, 0, 300);
        mode_run(0, 1, 5, 9);
        mode_run(0, 2, 0, 7);
        mode_run(0, 3, 1, 5);
        for (int i = 0; i < 8; i++)
        begin
            m = $urandom % 4;
            n = $urandom % 60;
            c = 2 + $urandom % 199;
            mode_run(0, m, n, c);
        end
        summarize();
    end
endmodule
